// ==== verification/pwmg_power_stage.sv ====
/*
  pwmg_power_stage: model of the half bridge behind the two pwm outputs.
  assumes gate drives change on clk; load current direction is set by the bench.
*/
`timescale 1ns/1ns
module pwmg_power_stage
(
    // clock and control
    input  wire logic        clk,
    input  wire logic        clr,
    input  wire logic        load_dir,
    // gate drives
    input  wire logic        high_output,
    input  wire logic        low_output,
    // current sense and on-time counts
    output logic             comp_input,
    output logic [15:0]      hi_cnt_ff,
    output logic [15:0]      lo_cnt_ff,
    output logic [15:0]      ov_cnt_ff
);
    // sense pin follows the load current sign; it is asynchronous to the block
    assign comp_input = load_dir;

    // both switches on is shoot-through; counted so negative dead time shows
    always_ff @(posedge clk)
    begin
        if (clr)
        begin
            hi_cnt_ff <= 16'h0000;
            lo_cnt_ff <= 16'h0000;
            ov_cnt_ff <= 16'h0000;
        end
        else
        begin
            hi_cnt_ff <= hi_cnt_ff + 16'(high_output === 1'b1);
            lo_cnt_ff <= lo_cnt_ff + 16'(low_output === 1'b1);
            ov_cnt_ff <= ov_cnt_ff + 16'(high_output === 1'b1 && low_output === 1'b1);
        end
    end
endmodule

// ==== verification/pwmg_top_test.sv ====
/*
  pwmg_top_test: self-checking bench for the pwm generator mode control block.
  assumes the power stage model and the design package are compiled first.
*/
`timescale 1ns/1ns
module pwmg_top_test
    import pwmg_pkg::*;
;
    logic        clk          = 1'b0;
    logic        resetn       = 1'b0;
    logic        wb_cyc_i     = 1'b0;
    logic        wb_stb_i     = 1'b0;
    logic        wb_we_i      = 1'b0;
    logic [7:0]  wb_adr_i     = 8'h00;
    logic [31:0] wb_dat_i     = 32'h0;
    logic        wb_ack_o;
    logic [31:0] wb_dat_o;
    logic        prim_tb_sync = 1'b0;
    logic        sec_tb_sync  = 1'b0;
    logic        sec_present  = 1'b0;
    logic        sec_en       = 1'b0;
    logic        current_limit = 1'b0;
    logic        comp_input;
    logic        high_output;
    logic        low_output;
    logic        clr          = 1'b0;
    logic        load_dir     = 1'b0;
    logic [15:0] hi_cnt_ff;
    logic [15:0] lo_cnt_ff;
    logic [15:0] ov_cnt_ff;
    logic [3:0]  tick_ff      = 4'h0;
    int          error_cnt    = 0;
    int          compares     = 0;

    // dead-time table: control word, load direction, expected high, low, overlap per 100 cycles
    localparam logic [15:0] DT_CTL [8] = '{16'h0280, 16'h0200, 16'h0220, 16'h0240,
                                           16'h02c0, 16'h02c0, 16'h02e0, 16'h02e0};
    localparam logic        DT_DIR [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    localparam logic [7:0]  DT_HI  [8] = '{8'h32, 8'h1e, 8'h1e, 8'h46, 8'h0a, 8'h32, 8'h32, 8'h0a};
    localparam logic [7:0]  DT_LO  [8] = '{8'h32, 8'h1e, 8'h1e, 8'h46, 8'h32, 8'h0a, 8'h0a, 8'h32};
    localparam logic [7:0]  DT_OV  [8] = '{8'h00, 8'h00, 8'h00, 8'h28, 8'h00, 8'h00, 8'h00, 8'h00};

    always #10 clk = ~clk;

    // master time bases: primary every 16 cycles, secondary every 8 when enabled
    always_ff @(posedge clk)
    begin
        tick_ff      <= tick_ff + 4'h1;
        prim_tb_sync <= (tick_ff == 4'hf);
        sec_tb_sync  <= sec_en && (tick_ff[2:0] == 3'h7);
    end

    pwmg_top pwmg_top_inst (
        .clk            (clk),
        .resetn         (resetn),
        .wb_cyc_i       (wb_cyc_i),
        .wb_stb_i       (wb_stb_i),
        .wb_we_i        (wb_we_i),
        .wb_adr_i       (wb_adr_i),
        .wb_sel_i       (4'h3),
        .wb_dat_i       (wb_dat_i),
        .wb_ack_o       (wb_ack_o),
        .wb_dat_o       (wb_dat_o),
        .prim_tb_sync   (prim_tb_sync),
        .sec_tb_sync    (sec_tb_sync),
        .sec_tb_present (sec_present),
        .comp_input     (comp_input),
        .current_limit  (current_limit),
        .high_output    (high_output),
        .low_output     (low_output)
    );

    pwmg_power_stage pwmg_power_stage_inst (
        .clk         (clk),
        .clr         (clr),
        .load_dir    (load_dir),
        .high_output (high_output),
        .low_output  (low_output),
        .comp_input  (comp_input),
        .hi_cnt_ff   (hi_cnt_ff),
        .lo_cnt_ff   (lo_cnt_ff),
        .ov_cnt_ff   (ov_cnt_ff)
    );

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one classic cycle; request held until ack is sampled, no fixed latency assumed
    task automatic wb_xfer(input logic [7:0] adr, input logic we, input logic [15:0] wd,
                           output logic [31:0] rd);
        int n;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {16'h0000, wd};
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 20)
            chk("wb_ack", 32'h1, 32'h0);
    endtask

    task automatic cfg(input logic [15:0] ctl, per, duty, dead);
        logic [31:0] rd;
        wb_xfer(ADR_DEAD, 1'b1, dead, rd);
        wb_xfer(ADR_DUTY, 1'b1, duty, rd);
        wb_xfer(ADR_CTRL, 1'b1, ctl, rd);
        // a short period forces an early restart, so the new mode loads before a long period can stall it
        wb_xfer(ADR_PERIOD, 1'b1, 16'h000f, rd);
        repeat (80) @(posedge clk);
        wb_xfer(ADR_PERIOD, 1'b1, per, rd);
        repeat (80) @(posedge clk);
    endtask

    task automatic meas(input int n);
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic t_regs();
        logic [31:0] rd;
        wb_xfer(ADR_CTRL, 1'b0, 16'h0000, rd);
        chk("ctrl_rst", 32'h0, rd);
        wb_xfer(ADR_PERIOD, 1'b0, 16'h0000, rd);
        chk("period_rst", 32'h0000ffff, rd);
        wb_xfer(8'h20, 1'b0, 16'h0000, rd);
        chk("unmapped", 32'h0, rd);
        wb_xfer(ADR_CTRL, 1'b1, 16'hffff, rd);
        wb_xfer(ADR_CTRL, 1'b0, 16'h0000, rd);
        chk("ctrl_mask", 32'h000002ef, rd);
        // the block raises no interrupt flag, so there is nothing to clear in two places
        $display("test regs done");
    endtask

    // period 9 gives a 10-cycle frame, duty 5, dead time 2
    task automatic t_dead();
        // limit pin held high must not disturb the frames while current_limit_period_reset is clear
        current_limit <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            load_dir <= DT_DIR[i];
            cfg(DT_CTL[i], 16'h0009, 16'h0005, 16'h0002);
            meas(100);
            chk("high_on", {24'h0, DT_HI[i]}, {16'h0, hi_cnt_ff});
            chk("low_on", {24'h0, DT_LO[i]}, {16'h0, lo_cnt_ff});
            chk("overlap", {24'h0, DT_OV[i]}, {16'h0, ov_cnt_ff});
        end
        current_limit <= 1'b0;
        $display("test dead done");
    endtask

    task automatic t_tbsel();
        logic [31:0] rd;
        sec_en      <= 1'b1;
        sec_present <= 1'b1;
        cfg(16'h0088, 16'hffff, 16'h0005, 16'h0000);
        for (int i = 0; i < 3; i++)
        begin
            repeat (5) @(posedge clk);
            wb_xfer(ADR_STATUS, 1'b0, 16'h0000, rd);
            chk("sec_restart", 32'h1, {31'h0, rd[15:0] < 16'h0008});
        end
        // center bit without independent time base must stay edge aligned
        // secondary pulses keep running until the new mode has been loaded by one of them
        cfg(16'h0084, 16'hffff, 16'h0005, 16'h0000);
        sec_en <= 1'b0;
        meas(160);
        chk("no_itb_cam", 32'h32, {16'h0, hi_cnt_ff});
        $display("test time base done");
    endtask

    // window is a multiple of every plausible center frame length
    task automatic t_center();
        logic [15:0] h1;
        cfg(16'h0204, 16'h000f, 16'h0009, 16'h0004);
        meas(14880);
        h1 = hi_cnt_ff;
        cfg(16'h0204, 16'h000f, 16'h0008, 16'h0000);
        meas(14880);
        chk("center_lsb", {16'h0, hi_cnt_ff}, {16'h0, h1});
        chk("center_on", 32'h1, {31'h0, h1 != 16'h0000});
        $display("test center done");
    endtask

    task automatic t_reset_upd();
        logic [31:0] rd;
        cfg(16'h0282, 16'h03e8, 16'h0000, 16'h0000);
        current_limit <= 1'b1;
        repeat (10) @(posedge clk);
        wb_xfer(ADR_STATUS, 1'b0, 16'h0000, rd);
        chk("limit_reset", 32'h1, {31'h0, rd[15:0] < 16'h0008});
        current_limit <= 1'b0;
        repeat (20) @(posedge clk);
        wb_xfer(ADR_STATUS, 1'b0, 16'h0000, rd);
        chk("limit_free", 32'h1, {31'h0, rd[15:0] > 16'h000f});
        wb_xfer(ADR_DUTY, 1'b1, 16'h03e8, rd);
        repeat (10) @(posedge clk);
        wb_xfer(ADR_STATUS, 1'b0, 16'h0000, rd);
        chk("duty_held", 32'h0, {31'h0, rd[STS_HIGH]});
        wb_xfer(ADR_CTRL, 1'b1, 16'h0283, rd);
        repeat (10) @(posedge clk);
        wb_xfer(ADR_STATUS, 1'b0, 16'h0000, rd);
        chk("duty_now", 32'h1, {31'h0, rd[STS_HIGH]});
        $display("test reset and update done");
    endtask

    initial
    begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        t_regs();
        t_dead();
        t_tbsel();
        t_center();
        t_reset_upd();
        tally_and_finish();
    end

    initial
    begin
        repeat (50000) @(posedge clk);
        error_cnt++;
        tally_and_finish();
    end
endmodule

// ==== verilog/pwmg_edge_shaper.sv ====
/*
  pwmg_edge_shaper: delays the rising and the falling edge of one level by
  programmable cycle counts; used once per pwm output.
  assumes in_lvl comes from logic on clk.
*/
`timescale 1ns/1ns
module pwmg_edge_shaper
    import pwmg_pkg::*;
#(
    parameter int W = 17
)
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         resetn,
    // level and edge delays
    input  wire logic         in_lvl,
    input  wire logic [W-1:0] rise_dly,
    input  wire logic [W-1:0] fall_dly,
    // shaped level
    output logic              out_lvl
);

    logic [W-1:0] cnt_ff;
    logic         out_ff;
    logic [W-1:0] dly_sel;

    assign dly_sel = in_lvl ? rise_dly : fall_dly;
    assign out_lvl = out_ff;

    // a pulse shorter than its delay is swallowed, so outputs never chatter
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            out_ff <= 1'b0;
            cnt_ff <= '0;
        end
        else if (in_lvl != out_ff)
        begin
            if (cnt_ff >= dly_sel)
            begin
                out_ff <= in_lvl;
                cnt_ff <= '0;
            end
            else
            begin
                cnt_ff <= cnt_ff + 1'b1;
            end
        end
        else
        begin
            cnt_ff <= '0;
        end
    end

    delay_honoured_a: assert property (@(posedge clk) disable iff (!resetn)
        $changed(out_ff) |-> $past(cnt_ff) >= $past(dly_sel))
        else $error("shaped edge came before its delay");

endmodule

// ==== verilog/pwmg_pkg.sv ====
/*
  pwmg_pkg: register map, field positions, reset values and shared types of the
  pwm generator mode control block.
  assumes a 32-bit classic wishbone bus with byte addresses on wb_adr_i.
*/
package pwmg_pkg;

    // register byte offsets
    localparam logic [7:0]  ADR_CTRL      = 8'h00;
    localparam logic [7:0]  ADR_PERIOD    = 8'h04;
    localparam logic [7:0]  ADR_DUTY      = 8'h08;
    localparam logic [7:0]  ADR_DEAD      = 8'h0c;
    localparam logic [7:0]  ADR_STATUS    = 8'h10;

    // control field positions
    localparam int          BIT_IUE       = 0;
    localparam int          BIT_CURRENT_LIMIT_PERIOD_RESET     = 1;
    localparam int          BIT_CAM       = 2;
    localparam int          BIT_TIME_BASE_SELECT      = 3;
    localparam int          BIT_POL       = 5;
    localparam int          DTM_LSB       = 6;
    localparam int          BIT_ITB       = 9;

    // status field positions
    localparam int          STS_DIR       = 16;
    localparam int          STS_HIGH      = 17;
    localparam int          STS_LOW       = 18;

    // reset values
    localparam logic [15:0] CTRL_RST      = 16'h0000;
    localparam logic [15:0] PERIOD_RST    = 16'hffff;
    localparam logic [15:0] DUTY_RST      = 16'h0000;
    localparam logic [15:0] DEAD_RST      = 16'h0000;

    // writable control bits; bits 4 and 8 and bits 10 to 15 read as zero
    localparam logic [15:0] CTRL_WMASK    = 16'h02ef;
    // center-aligned operation drops the three low bits
    localparam logic [15:0] CA_MASK       = 16'hfff8;

    typedef enum logic [1:0] {
        DTM_POS  = 2'b00,
        DTM_NEG  = 2'b01,
        DTM_OFF  = 2'b10,
        DTM_COMP = 2'b11
    } pwmg_dtm_t;

    typedef enum logic {
        DIR_UP   = 1'b0,
        DIR_DOWN = 1'b1
    } pwmg_dir_t;

    typedef struct packed {
        logic      independent_time_base_enable;
        pwmg_dtm_t dtm;
        logic      pol;
        logic      time_base_select;
        logic      center_align_enable;
        logic      current_limit_period_reset;
        logic      immediate_update;
    } pwmg_ctrl_t;

    // on-delay and off-delay of one output, in clock cycles
    typedef struct packed {
        logic [16:0] rise;
        logic [16:0] fall;
    } pwmg_shape_t;

endpackage

// ==== verilog/pwmg_top.sv ====
/*
  pwmg_top: mode control of one pwm generator with its time base, duty compare,
  dead-time shaping and a wishbone register slave.
  assumes master sync pulses come from logic on clk; comp_input and
  current_limit are asynchronous pins.
*/
`timescale 1ns/1ns
// Overview of operation
// - dead_time_mode 11 selects compensation, 10 no dead time, 01 negative dead time, 00 positive dead time.
// - with comp_polarity set, comp_input low shortens low_output and lengthens high_output, high does the reverse.
// - with comp_polarity clear, comp_input low shortens high_output and lengthens low_output, high does the reverse.
// - comp_polarity matters only while dead_time_mode is 11 and is ignored otherwise.
// - time_base_select set follows the secondary master time base if present, clear the primary one.
// - center_align_enable set gives center-aligned generation, clear gives edge-aligned generation.
// - center_align_enable acts only with independent_time_base_enable set, else edge alignment is used.
// - center-aligned operation ignores the three low bits of duty and dead time.
// - current_limit_period_reset lets the current-limit input reset an independent time base, else pins do not.
// - immediate_update set applies duty writes at once, clear applies them in step with the time base.
module pwmg_top
    import pwmg_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic             wb_ack_o,
    output logic [31:0]      wb_dat_o,
    // master time bases
    input  wire logic        prim_tb_sync,
    input  wire logic        sec_tb_sync,
    input  wire logic        sec_tb_present,
    // pins
    input  wire logic        comp_input,
    input  wire logic        current_limit,
    output logic             high_output,
    output logic             low_output
);

    logic        ack_ff;
    logic [31:0] rdata_ff;
    logic [15:0] ctrl_ff;
    logic [15:0] period_ff;
    logic [15:0] duty_ff;
    logic [15:0] dead_ff;
    pwmg_ctrl_t  ctrl_act_ff;
    logic [15:0] duty_act_ff;
    logic [15:0] cnt_ff;
    pwmg_dir_t   dir_ff;
    logic        raw_ff;
    logic        comp_meta_ff;
    logic        comp_sync_ff;
    logic        cl_meta_ff;
    logic        cl_sync_ff;

    logic        wb_req;
    logic        wb_wr;
    logic [15:0] lane_mask;
    pwmg_ctrl_t  ctrl_wr;
    logic        center;
    logic        sel_sync;
    logic        cl_reset;
    logic        tb_restart;
    logic [15:0] duty_eff;
    logic [15:0] dt_eff;
    logic [16:0] dt_one;
    logic [16:0] dt_two;
    pwmg_shape_t shape_h;
    pwmg_shape_t shape_l;
    logic        high_lvl;
    logic        low_lvl;

    // register slave

    assign wb_req    = wb_cyc_i && wb_stb_i && !ack_ff;
    assign wb_wr     = wb_req && wb_we_i;
    assign lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wb_ack_o  = ack_ff;
    assign wb_dat_o  = rdata_ff;

    assign ctrl_wr = '{independent_time_base_enable:   ctrl_ff[BIT_ITB],
                       dtm:   pwmg_dtm_t'(ctrl_ff[DTM_LSB+1:DTM_LSB]),
                       pol:   ctrl_ff[BIT_POL],
                       time_base_select:  ctrl_ff[BIT_TIME_BASE_SELECT],
                       center_align_enable:   ctrl_ff[BIT_CAM],
                       current_limit_period_reset: ctrl_ff[BIT_CURRENT_LIMIT_PERIOD_RESET],
                       immediate_update:   ctrl_ff[BIT_IUE]};

    // every access is answered one cycle later; unmapped reads give zero
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ack_ff <= 1'b0;
        end
        else
        begin
            ack_ff <= wb_req;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdata_ff <= 32'h0000_0000;
        end
        else if (wb_req && !wb_we_i)
        begin
            unique case (wb_adr_i)
                ADR_CTRL:   rdata_ff <= {16'h0000, ctrl_ff};
                ADR_PERIOD: rdata_ff <= {16'h0000, period_ff};
                ADR_DUTY:   rdata_ff <= {16'h0000, duty_ff};
                ADR_DEAD:   rdata_ff <= {16'h0000, dead_ff};
                ADR_STATUS: rdata_ff <= {13'h0000, low_output, high_output, dir_ff, cnt_ff};
                default:    rdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // writes land in the shadow copies on clk
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_ff   <= CTRL_RST;
            period_ff <= PERIOD_RST;
            duty_ff   <= DUTY_RST;
            dead_ff   <= DEAD_RST;
        end
        else if (wb_wr)
        begin
            unique case (wb_adr_i)
                ADR_CTRL:   ctrl_ff   <= (ctrl_ff & ~lane_mask) | (wb_dat_i[15:0] & lane_mask & CTRL_WMASK);
                ADR_PERIOD: period_ff <= (period_ff & ~lane_mask) | (wb_dat_i[15:0] & lane_mask);
                ADR_DUTY:   duty_ff   <= (duty_ff & ~lane_mask) | (wb_dat_i[15:0] & lane_mask);
                ADR_DEAD:   dead_ff   <= (dead_ff & ~lane_mask) | (wb_dat_i[15:0] & lane_mask);
                default:    ;
            endcase
        end
    end

    // pin synchronisers

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            comp_meta_ff <= 1'b0;
            comp_sync_ff <= 1'b0;
            cl_meta_ff   <= 1'b0;
            cl_sync_ff   <= 1'b0;
        end
        else
        begin
            comp_meta_ff <= comp_input;
            comp_sync_ff <= comp_meta_ff;
            cl_meta_ff   <= current_limit;
            cl_sync_ff   <= cl_meta_ff;
        end
    end

    // time base

    assign center   = ctrl_act_ff.center_align_enable && ctrl_act_ff.independent_time_base_enable;
    assign sel_sync = (ctrl_act_ff.time_base_select && sec_tb_present) ? sec_tb_sync : prim_tb_sync;
    assign cl_reset = ctrl_act_ff.independent_time_base_enable && ctrl_act_ff.current_limit_period_reset && cl_sync_ff;

    always_comb
    begin
        if (!ctrl_act_ff.independent_time_base_enable)
        begin
            tb_restart = sel_sync;
        end
        else if (cl_reset || period_ff == 16'h0000)
        begin
            tb_restart = 1'b1;
        end
        else if (center)
        begin
            tb_restart = (dir_ff == DIR_DOWN) && (cnt_ff == 16'h0000);
        end
        else
        begin
            tb_restart = (cnt_ff >= period_ff);
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt_ff <= 16'h0000;
            dir_ff <= DIR_UP;
        end
        else if (tb_restart)
        begin
            cnt_ff <= 16'h0000;
            dir_ff <= DIR_UP;
        end
        else if (center && (dir_ff == DIR_DOWN || cnt_ff >= period_ff))
        begin
            cnt_ff <= cnt_ff - 16'h0001;
            dir_ff <= DIR_DOWN;
        end
        else
        begin
            cnt_ff <= cnt_ff + 16'h0001;
        end
    end

    // mode fields change only at a time-base boundary so a period never mixes modes
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_act_ff <= '0;
        end
        else if (tb_restart)
        begin
            ctrl_act_ff <= ctrl_wr;
        end
    end

    // immediate update tracks the shadow at once, otherwise duty waits for the boundary
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            duty_act_ff <= DUTY_RST;
        end
        else if (tb_restart || ctrl_wr.immediate_update)
        begin
            duty_act_ff <= duty_ff;
        end
    end

    // compare and dead time

    assign duty_eff = center ? (duty_act_ff & CA_MASK) : duty_act_ff;
    assign dt_eff   = center ? (dead_ff & CA_MASK) : dead_ff;
    assign dt_one   = {1'b0, dt_eff};
    assign dt_two   = {dt_eff, 1'b0};

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            raw_ff <= 1'b0;
        end
        else
        begin
            raw_ff <= (cnt_ff < duty_eff);
        end
    end

    // compensation puts the whole dead interval on the shortened output's rising edge
    always_comb
    begin
        shape_h = '0;
        shape_l = '0;
        unique case (ctrl_act_ff.dtm)
            DTM_POS:
            begin
                shape_h.rise = dt_one;
                shape_l.rise = dt_one;
            end
            DTM_NEG:
            begin
                shape_h.fall = dt_one;
                shape_l.fall = dt_one;
            end
            DTM_OFF:
            begin
                shape_h = '0;
                shape_l = '0;
            end
            DTM_COMP:
            begin
                if (ctrl_act_ff.pol == comp_sync_ff)
                begin
                    shape_h.rise = dt_two;
                end
                else
                begin
                    shape_l.rise = dt_two;
                end
            end
        endcase
    end

    pwmg_edge_shaper #(.W(17)) u_high
    (
        .clk      (clk),
        .resetn   (resetn),
        .in_lvl   (raw_ff),
        .rise_dly (shape_h.rise),
        .fall_dly (shape_h.fall),
        .out_lvl  (high_lvl)
    );

    pwmg_edge_shaper #(.W(17)) u_low
    (
        .clk      (clk),
        .resetn   (resetn),
        .in_lvl   (!raw_ff),
        .rise_dly (shape_l.rise),
        .fall_dly (shape_l.fall),
        .out_lvl  (low_lvl)
    );

    assign high_output = high_lvl;
    assign low_output  = low_lvl;

    // checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    pos_dead_a: assert property (ctrl_act_ff.dtm == DTM_POS |-> shape_h.rise == dt_one && shape_l.fall == 17'h00000)
        else $error("positive dead time shape wrong");
    neg_dead_a: assert property (ctrl_act_ff.dtm == DTM_NEG |-> shape_l.fall == dt_one && shape_h.rise == 17'h00000)
        else $error("negative dead time shape wrong");
    no_dead_a: assert property (ctrl_act_ff.dtm == DTM_OFF |-> shape_h == '0 && shape_l == '0)
        else $error("disabled dead time still shapes");
    pol_one_a: assert property (ctrl_act_ff.dtm == DTM_COMP && ctrl_act_ff.pol |->
        (comp_sync_ff ? shape_h.rise : shape_l.rise) == dt_two)
        else $error("set polarity shortens wrong output");
    pol_zero_a: assert property (ctrl_act_ff.dtm == DTM_COMP && !ctrl_act_ff.pol |->
        (comp_sync_ff ? shape_l.rise : shape_h.rise) == dt_two)
        else $error("clear polarity shortens wrong output");
    pol_ignored_a: assert property (ctrl_act_ff.dtm != DTM_COMP |-> shape_h == shape_l)
        else $error("polarity acted outside compensation");
    sec_sync_a: assert property (!ctrl_act_ff.independent_time_base_enable && ctrl_act_ff.time_base_select && sec_tb_present && sec_tb_sync
        |=> cnt_ff == 16'h0000)
        else $error("secondary sync did not restart time base");
    turn_down_a: assert property (center && dir_ff == DIR_UP && cnt_ff == period_ff && !tb_restart
        |=> dir_ff == DIR_DOWN && cnt_ff == $past(cnt_ff) - 16'h0001)
        else $error("center mode did not turn down");
    edge_only_a: assert property (!ctrl_act_ff.independent_time_base_enable |-> dir_ff == DIR_UP)
        else $error("counted down without independent time base");
    low_bits_a: assert property (center |-> duty_eff[2:0] == 3'h0 && dt_eff[2:0] == 3'h0)
        else $error("center mode kept low bits");
    cl_reset_a: assert property (ctrl_act_ff.independent_time_base_enable && ctrl_act_ff.current_limit_period_reset && cl_sync_ff
        |=> cnt_ff == 16'h0000 && dir_ff == DIR_UP)
        else $error("current limit did not reset time base");
    imm_duty_a: assert property (ctrl_wr.immediate_update |=> duty_act_ff == $past(duty_ff))
        else $error("immediate duty update missed");
    held_mode_a: assert property (!tb_restart |=> ctrl_act_ff == $past(ctrl_act_ff))
        else $error("mode changed inside a period");
    comp_sync_a: assert property (##2 comp_sync_ff == $past(comp_input, 2))
        else $error("comp input not two flops late");

    center_turn_c: cover property (center && dir_ff == DIR_DOWN ##1 tb_restart);
    cl_reset_c: cover property (cl_reset ##1 cnt_ff == 16'h0000);
    comp_mode_c: cover property (ctrl_act_ff.dtm == DTM_COMP && $rose(high_output));
    neg_overlap_c: cover property (high_output && low_output);

endmodule
